// [bench/framed_serial_port_asserts.sv]
// Purpose: port-level checks of the framed serial port
// Assumes: bound to framed_serial_port
// Notes: link checks run on the serial clock pin
module framed_serial_port_asserts (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic serialClock,
  input wire logic serialClockOut,
  input wire logic serialClockOe,
  input wire serial_port_pkg::framing_t framingMode,
  input wire logic rxValid,
  input wire logic [serial_port_pkg::WORD_W-1:0] rxWord,
  input wire logic serial_tx_line_a,
  input wire logic serial_tx_line_a_oe,
  input wire logic serial_tx_line_b,
  input wire logic serial_tx_line_b_oe,
  input wire logic internal_frame_pulse
);
  timeunit 1ns;
  timeprecision 100ps;
  import serial_port_pkg::*;
  logic [1:0] atFall;
  logic [7:0] run;
  logic seen;
  // cleared in reset so the first rise after release does not compare an unknown
  always_ff @(negedge serialClock or negedge rst_b) begin
    if (!rst_b) begin
      atFall <= 2'h0;
    end else begin
      atFall <= {serial_tx_line_a, serial_tx_line_b};
    end
  end
  // divider period only checked while the pin is ours
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      run <= 8'h00;
      seen <= 1'b0;
    end else begin
      run <= $changed(serialClockOut) ? 8'h01 : run + 8'h01;
      seen <= serialClockOe && (seen || $changed(serialClockOut));
    end
  end
  AST_TXOE_RESET: assert property (@(posedge clock)
    !rst_b |-> !serial_tx_line_a_oe && !serial_tx_line_b_oe) else $error("tx enable in reset");
  AST_SCLK_RESET: assert property (@(posedge clock)
    !rst_b |-> !serialClockOe) else $error("clock pin driven in reset");
  AST_TXOE_RUN: assert property (@(posedge serialClock) disable iff (!rst_b)
    rst_b [*4] |-> serial_tx_line_a_oe && serial_tx_line_b_oe) else $error("tx enable late");
  AST_RX_PULSE: assert property (@(posedge clock) disable iff (!rst_b)
    rxValid |=> !rxValid) else $error("rx valid too long");
  AST_RXWORD: assert property (@(posedge clock) disable iff (!rst_b)
    $changed(rxWord) |-> rxValid) else $error("rx word moved alone");
  AST_TX_HOLD: assert property (@(posedge serialClock) disable iff (!rst_b)
    {serial_tx_line_a, serial_tx_line_b} == atFall) else $error("tx bit moved before rise");
  AST_PULSE_WIDTH: assert property (@(posedge serialClock) disable iff (!rst_b)
    internal_frame_pulse |=> !internal_frame_pulse) else $error("frame pulse too wide");
  AST_FIXED_PERIOD: assert property (@(posedge serialClock) disable iff (!rst_b)
    framingMode == FRAMING_INT_FIXED && $past(framingMode, 4) == FRAMING_INT_FIXED
    && internal_frame_pulse |-> ##16 internal_frame_pulse) else $error("fixed period off");
  AST_SCLK_HALF: assert property (@(posedge clock) disable iff (!rst_b)
    seen && $changed(serialClockOut) |-> run == 8'h46) else $error("serial clock half period");
endmodule
bind framed_serial_port framed_serial_port_asserts chk_u (.clock(clock), .rst_b(rst_b),
  .serialClock(serialClock), .serialClockOut(serialClockOut), .serialClockOe(serialClockOe),
  .framingMode(framingMode), .rxValid(rxValid), .rxWord(rxWord),
  .serial_tx_line_a(serial_tx_line_a), .serial_tx_line_a_oe(serial_tx_line_a_oe),
  .serial_tx_line_b(serial_tx_line_b), .serial_tx_line_b_oe(serial_tx_line_b_oe),
  .internal_frame_pulse(internal_frame_pulse));

// [bench/framed_serial_port_tb.sv]
// Purpose: self-checking bench of the framed serial port
// Assumes: 250 MHz system clock, 64 ns codec clock from the partner
// Notes: fixed framing runs last, its pulses never stop
module framed_serial_port_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import serial_port_pkg::*;
  logic clock, serialClockOut, serialClockOe, txReady, rxValid, partnerClock;
  logic rst_b = 1'b1, driveSerialClock = 1'b0, txValid = 1'b0, rxOn = 1'b1;
  logic a, aOe, b, bOe, fsTx, fsRx, rxLine, pulse;
  framing_t framingMode = FRAMING_EXTERNAL;
  tx_pair_t txData = '0;
  logic [WORD_W-1:0] rxWord;
  logic [31:0] seed = 32'h7F89F73A, got;
  logic [15:0] rxQ[$];
  tx_pair_t txQ[$];
  int bad_count = 0, samples_checked = 0, cycles = 0, n = 0;
  wire sclkPin = serialClockOe ? serialClockOut : partnerClock;
  wire lineA = aOe ? a : 1'bz;
  wire lineB = bOe ? b : 1'bz;
  framed_serial_port dut_u (
    .clock(clock), .rst_b(rst_b), .serialClock(sclkPin), .serialClockOut(serialClockOut),
    .serialClockOe(serialClockOe), .framingMode(framingMode),
    .driveSerialClock(driveSerialClock), .txValid(txValid), .txReady(txReady),
    .txData(txData), .rxValid(rxValid), .rxWord(rxWord), .serial_tx_line_a(a),
    .serial_tx_line_a_oe(aOe), .serial_tx_line_b(b), .serial_tx_line_b_oe(bOe),
    .serial_rx_line(rxLine), .tx_frame_sync(fsTx), .rx_frame_sync(fsRx),
    .internal_frame_pulse(pulse)
  );
  serial_partner partner_u (.partnerClock(partnerClock), .pin(sclkPin), .txA(lineA),
    .txB(lineB), .framePulse(pulse), .fsTx(fsTx), .fsRx(fsRx), .rxLine(rxLine));
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // leaves txValid high so back-to-back pushes never drop it between words
  task automatic push(output logic ok);
    tx_pair_t d;
    d = tx_pair_t'(rnd());
    txValid <= 1'b1;
    txData <= d;
    @(posedge clock);
    ok = txReady;
    if (ok === 1'b1) txQ.push_back(d);
  endtask
  task automatic xfer(input logic ext);
    logic [15:0] r;
    tx_pair_t e;
    r = rnd();
    rxQ.push_back(r);
    e = (txQ.size() > 0) ? txQ.pop_front() : '0;
    partner_u.frame(ext, r, got);
    check("tx pair", e, got);
  endtask
  always @(posedge clock) begin
    if (rxOn && rxValid === 1'b1) begin
      if (rxQ.size() == 0) check("rx extra", 32'h1, 32'h0);
      else check("rx word", {16'h0, rxQ.pop_front()}, {16'h0, rxWord});
    end
  end
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      bad_count++;
      close_out();
    end
  end
  initial begin
    logic ok;
    @(posedge clock);
    rst_b <= 1'b0;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    repeat (200) @(posedge clock);
    ok = 1'b1;
    while (ok === 1'b1 && n < 40) begin
      push(ok);
      n++;
    end
    txValid <= 1'b0;
    check("fifo refuses", 32'h1, {31'h0, n > 33 && n < 40});
    repeat (n) xfer(1'b1);
    $display("test external framing done");
    framingMode <= FRAMING_INT_VARIABLE;
    repeat (200) @(posedge clock);
    push(ok);
    push(ok);
    txValid <= 1'b0;
    repeat (2) xfer(1'b0);
    $display("test variable framing done");
    @(posedge clock);
    framingMode <= FRAMING_EXTERNAL;
    driveSerialClock <= 1'b1;
    repeat (400) @(posedge clock);
    check("drive enables", 32'h7, {29'h0, serialClockOe, aOe, bOe});
    rst_b <= 1'b0;
    @(negedge clock);
    check("reset enables", 32'h0, {29'h0, serialClockOe, aOe, bOe});
    repeat (60) @(posedge clock);
    driveSerialClock <= 1'b0;
    rst_b <= 1'b1;
    repeat (200) @(posedge clock);
    check("enables after reset", 32'h3, {30'h0, aOe, bOe});
    $display("test reset done");
    push(ok);
    txValid <= 1'b0;
    repeat (100) @(posedge clock);
    framingMode <= FRAMING_INT_FIXED;
    xfer(1'b0);
    repeat (8) @(posedge clock);
    rxOn = 1'b0;
    repeat (600) @(posedge clock);
    $display("test fixed framing done");
    close_out();
  end
endmodule

// [bench/serial_partner.sv]
// Purpose: framed serial codec model at the far side of the port
// Assumes: codec clock of 64 ns runs free
// Notes: syncs driven only in external framing
module serial_partner (
  output logic partnerClock,
  input wire logic pin,
  input wire logic txA,
  input wire logic txB,
  input wire logic framePulse,
  output logic fsTx,
  output logic fsRx,
  output logic rxLine
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    partnerClock = 1'b0;
    fsTx = 1'b0;
    fsRx = 1'b0;
    rxLine = 1'b1;
    #13;
    forever #32 partnerClock = ~partnerClock;
  end
  task automatic frame(input logic ext, input logic [15:0] rxw, output logic [31:0] got);
    if (ext) begin
      @(posedge pin);
      fsTx <= 1'b1;
      fsRx <= 1'b1;
      @(negedge pin);
    end else begin
      do @(negedge pin); while (framePulse !== 1'b1);
    end
    for (int i = 15; i >= 0; i--) begin
      @(posedge pin);
      fsTx <= 1'b0;
      fsRx <= 1'b0;
      rxLine <= rxw[i];
      @(negedge pin);
      got[16+i] = txA;
      got[i] = txB;
    end
    @(posedge pin);
    rxLine <= ~rxw[0]; // undriven data must not look like the last bit
  endtask
endmodule

// [design/framed_serial_port.sv]
// Purpose: dual-channel frame-synchronised serial port, device side
// Assumes: serialClock is the serial clock pin as seen at the pad
// Notes: link logic runs on serialClock, user side on clock
//
// Overview of operation
// - every word is shifted most significant bit first, then descending.
// - each transmit bit holds until the next serial clock rising edge.
// - both transmit lines launch a bit before the falling edge sampling it.
// - receive line sampled on serial clock falling edge; sender holds it there.
// - external frame syncs are detected on a falling edge, marking word start.
// - internal framing makes its own pulse from a rising edge, both directions.
// - on reset both transmit lines go high impedance within 200 ns.
// - on reset the serial clock pin is no longer driven.
// - reset acts at once; only its release is synchronised to each local clock.
module framed_serial_port (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic serialClock,
  output logic serialClockOut,
  output logic serialClockOe,
  input wire serial_port_pkg::framing_t framingMode,
  input wire logic driveSerialClock,
  input wire logic txValid,
  output logic txReady,
  input wire serial_port_pkg::tx_pair_t txData,
  output logic rxValid,
  output logic [serial_port_pkg::WORD_W-1:0] rxWord,
  output logic serial_tx_line_a,
  output logic serial_tx_line_a_oe,
  output logic serial_tx_line_b,
  output logic serial_tx_line_b_oe,
  input wire logic serial_rx_line,
  input wire logic tx_frame_sync,
  input wire logic rx_frame_sync,
  output logic internal_frame_pulse
);
  import serial_port_pkg::*;

  // ---------------- resets ----------------
  logic [1:0] sysRstPipe;
  logic sysRst_b;
  logic [1:0] linkRstPipe;
  logic linkRst_b;

  // assert at once, release on the local clock
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sysRstPipe <= 2'h0;
    end else begin
      sysRstPipe <= {sysRstPipe[0], 1'b1};
    end
  end
  assign sysRst_b = sysRstPipe[1];

  always_ff @(posedge serialClock or negedge rst_b) begin
    if (!rst_b) begin
      linkRstPipe <= 2'h0;
    end else begin
      linkRstPipe <= {linkRstPipe[0], 1'b1};
    end
  end
  assign linkRst_b = linkRstPipe[1];

  // ---------------- serial clock driver ----------------
  logic [SCLK_DIV_W-1:0] divCount;
  wire divWrap = (divCount == SCLK_DIV_W'(SCLK_HALF_CYCLES - 1));

  // equal halves keep the duty at 50 percent and each phase above the least
  always_ff @(posedge clock or negedge sysRst_b) begin
    if (!sysRst_b) begin
      divCount <= DIV_RESET;
      serialClockOut <= 1'b0;
      serialClockOe <= 1'b0;
    end else begin
      divCount <= divWrap ? DIV_RESET : divCount + 1'b1;
      if (divWrap) begin
        serialClockOut <= !serialClockOut;
      end
      serialClockOe <= driveSerialClock;
    end
  end

  // ---------------- transmit buffering ----------------
  logic fifoOutValid;
  logic [TX_PAIR_W-1:0] fifoOutData;
  tx_pair_t txXfer;
  logic txAck;
  logic txReq;
  logic [1:0] txReqSync;
  wire slotFree = (txReqSync[1] == txAck);
  wire takeWord = fifoOutValid && slotFree;

  word_fifo #(
    .WIDTH(TX_PAIR_W),
    .DEPTH(TX_FIFO_DEPTH)
  ) txFifo (
    .clock(clock),
    .rst_b(sysRst_b),
    .inValid(txValid),
    .inReady(txReady),
    .inData(txData),
    .outValid(fifoOutValid),
    .outReady(slotFree),
    .outData(fifoOutData)
  );

  // word handed to the link by toggle handshake; held until the next request
  always_ff @(posedge clock or negedge sysRst_b) begin
    if (!sysRst_b) begin
      txReqSync <= 2'h0;
      txAck <= 1'b0;
      txXfer <= '0;
    end else begin
      txReqSync <= {txReqSync[0], txReq};
      if (takeWord) begin
        txXfer <= fifoOutData;
        txAck <= !txAck;
      end
    end
  end

  // ---------------- link side: configuration crossing ----------------
  framing_t modeMeta;
  framing_t linkMode;
  logic [1:0] ackSync;

  // mode is static in use; a change mid-word may split one frame
  always_ff @(posedge serialClock or negedge linkRst_b) begin
    if (!linkRst_b) begin
      modeMeta <= FRAMING_EXTERNAL;
      linkMode <= FRAMING_EXTERNAL;
      ackSync <= 2'h0;
    end else begin
      modeMeta <= framingMode;
      linkMode <= modeMeta;
      ackSync <= {ackSync[0], txAck};
    end
  end

  wire internalMode = (linkMode != FRAMING_EXTERNAL);
  wire wordFilled = (ackSync[1] != txReq);

  // ---------------- link side: frame detection (falling edge) ----------------
  logic txFsSeen;
  logic rxFsSeen;
  wire txFsSource = internalMode ? internal_frame_pulse : tx_frame_sync;
  wire rxFsSource = internalMode ? internal_frame_pulse : rx_frame_sync;

  always_ff @(negedge serialClock or negedge linkRst_b) begin
    if (!linkRst_b) begin
      txFsSeen <= 1'b0;
      rxFsSeen <= 1'b0;
    end else begin
      txFsSeen <= txFsSource;
      rxFsSeen <= rxFsSource;
    end
  end

  // ---------------- link side: transmit (rising edge) ----------------
  logic [WORD_W-1:0] shiftA;
  logic [WORD_W-1:0] shiftB;
  logic [BIT_CNT_W-1:0] txBitsLeft;
  logic [3:0] frameCount;
  wire txIdle = (txBitsLeft == BITS_NONE) && !txFsSeen && !internal_frame_pulse;
  wire [WORD_W-1:0] loadA = wordFilled ? txXfer.lineA : WORD_RESET;
  wire [WORD_W-1:0] loadB = wordFilled ? txXfer.lineB : WORD_RESET;
  wire fixedPulse = (linkMode == FRAMING_INT_FIXED) && (frameCount == FRAME_LAST);
  wire varPulse = (linkMode == FRAMING_INT_VARIABLE) && txIdle && wordFilled;

  // an underrun in fixed or external framing sends a zero word
  always_ff @(posedge serialClock or negedge linkRst_b) begin
    if (!linkRst_b) begin
      serial_tx_line_a <= 1'b0;
      serial_tx_line_b <= 1'b0;
      serial_tx_line_a_oe <= 1'b0;
      serial_tx_line_b_oe <= 1'b0;
      shiftA <= WORD_RESET;
      shiftB <= WORD_RESET;
      txBitsLeft <= BITS_NONE;
      txReq <= 1'b0;
      frameCount <= FRAME_RESET;
      internal_frame_pulse <= 1'b0;
    end else begin
      serial_tx_line_a_oe <= 1'b1;
      serial_tx_line_b_oe <= 1'b1;
      frameCount <= frameCount + 1'b1;
      internal_frame_pulse <= fixedPulse || varPulse;
      if (txFsSeen) begin
        serial_tx_line_a <= loadA[WORD_W-1];
        serial_tx_line_b <= loadB[WORD_W-1];
        shiftA <= {loadA[WORD_W-2:0], 1'b0};
        shiftB <= {loadB[WORD_W-2:0], 1'b0};
        txBitsLeft <= BITS_LAST;
        if (wordFilled) begin
          txReq <= !txReq;
        end
      end else if (txBitsLeft != BITS_NONE) begin
        serial_tx_line_a <= shiftA[WORD_W-1];
        serial_tx_line_b <= shiftB[WORD_W-1];
        shiftA <= {shiftA[WORD_W-2:0], 1'b0};
        shiftB <= {shiftB[WORD_W-2:0], 1'b0};
        txBitsLeft <= txBitsLeft - 1'b1;
      end
    end
  end

  // ---------------- link side: receive (falling edge) ----------------
  logic [WORD_W-1:0] rxShift;
  logic [BIT_CNT_W-1:0] rxCount;
  logic [WORD_W-1:0] rxHold;
  logic rxToggle;
  wire rxActive = (rxCount != BITS_NONE) && (rxCount != BITS_FULL);
  wire [WORD_W-1:0] rxNextShift = {rxShift[WORD_W-2:0], serial_rx_line};
  wire rxWordDone = rxActive && (rxCount == BITS_LAST);

  always_ff @(negedge serialClock or negedge linkRst_b) begin
    if (!linkRst_b) begin
      rxShift <= WORD_RESET;
      rxCount <= BITS_NONE;
      rxHold <= WORD_RESET;
      rxToggle <= 1'b0;
    end else begin
      if (rxFsSeen) begin
        rxShift <= {{(WORD_W-1){1'b0}}, serial_rx_line};
        rxCount <= 5'h01;
      end else if (rxActive) begin
        rxShift <= rxNextShift;
        rxCount <= rxCount + 1'b1;
      end
      if (rxWordDone && !rxFsSeen) begin
        rxHold <= rxNextShift;
        rxToggle <= !rxToggle;
      end
    end
  end

  // ---------------- receive word into the system domain ----------------
  logic [2:0] rxToggleSync;
  wire rxArrived = rxToggleSync[2] != rxToggleSync[1];

  // rxHold stays still for a whole word, far longer than the crossing
  always_ff @(posedge clock or negedge sysRst_b) begin
    if (!sysRst_b) begin
      rxToggleSync <= 3'h0;
      rxValid <= 1'b0;
      rxWord <= WORD_RESET;
    end else begin
      rxToggleSync <= {rxToggleSync[1:0], rxToggle};
      rxValid <= rxArrived;
      if (rxArrived) begin
        rxWord <= rxHold;
      end
    end
  end

endmodule

// [design/serial_port_pkg.sv]
// Purpose: shared constants and types of the dual-channel framed serial port
// Assumes: system clock at 250 MHz
// Notes: times in ns, cycle counts derived from them
package serial_port_pkg;

  localparam int WORD_W = 16;
  localparam int TX_FIFO_DEPTH = 32;
  localparam int BIT_CNT_W = 5;

  localparam int SYS_CLK_PERIOD_NS = 4;
  // shortest legal serial clock period
  localparam int SCLK_MIN_PERIOD_NS = 555;
  // half period in system cycles, rounded up so the period never drops below the least
  localparam int SCLK_HALF_CYCLES =
    (SCLK_MIN_PERIOD_NS + 2 * SYS_CLK_PERIOD_NS - 1) / (2 * SYS_CLK_PERIOD_NS);
  localparam int SCLK_DIV_W = 8;

  // release of transmit lines after reset, longest time
  localparam int TX_RELEASE_NS = 200;

  localparam logic [BIT_CNT_W-1:0] BITS_LAST = 5'h0F;
  localparam logic [BIT_CNT_W-1:0] BITS_FULL = 5'h10;
  localparam logic [BIT_CNT_W-1:0] BITS_NONE = 5'h00;
  localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;
  localparam logic [3:0] FRAME_LAST = 4'hF;
  localparam logic [3:0] FRAME_RESET = 4'h0;
  localparam logic [SCLK_DIV_W-1:0] DIV_RESET = 8'h00;

  typedef enum logic [1:0] {
    FRAMING_EXTERNAL,
    FRAMING_INT_FIXED,
    FRAMING_INT_VARIABLE
  } framing_t;

  typedef struct packed {
    logic [WORD_W-1:0] lineA;
    logic [WORD_W-1:0] lineB;
  } tx_pair_t;

  localparam int TX_PAIR_W = 2 * WORD_W;

endpackage

// [design/word_fifo.sv]
// Purpose: synchronous FIFO with registered output stage
// Assumes: one clock, asynchronous active-low reset
// Notes: capacity is DEPTH words in memory plus one in the output register
module word_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;
  logic [AW:0] count;

  wire push = inValid && inReady;
  wire memHasData = (count != '0);
  wire pop = memHasData && (!outValid || outReady);
  wire [AW:0] next_count = count + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wrPtr] <= inData;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
      inReady <= 1'b0;
      outValid <= 1'b0;
      outData <= '0;
    end else begin
      if (push) begin
        wrPtr <= (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
      end
      if (pop) begin
        rdPtr <= (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
        outData <= mem[rdPtr];
        outValid <= 1'b1;
      end else if (outReady) begin
        outValid <= 1'b0;
      end
      count <= next_count;
      // registered so the source sees honest back-pressure
      inReady <= (next_count < (AW+1)'(DEPTH));
    end
  end
endmodule
